// ### pio_pkg.sv
// constants, register map and control layout of the dual parallel i/o block
//
// Behaviour
// R1: The block answers in two address blocks of eight ports, one block per interface unit, each picked by its own select.
//     The code decodes four per block: the three port data registers and the control register.
// R2: There are two independent units of 24 lines, each split into two groups of 12 that each run one of three modes.
//     The code gives the second group only two modes, basic and strobed.
// R3: In basic mode every set of four lines in a group has its own input or output direction. The code sets one per port and per half of the third port.
// R4: In strobed mode a group uses eight lines as one port and three of its other four lines for handshake and interrupt.
//     The code takes the first group's interrupt line from the other group: line 3 of the third port.
// R5: In bidirectional mode the first port is an eight-line two-way bus with five handshake lines, one taken from the other group.
// R6: Software can set or clear one line of the third port without touching the others.
// R7: Each unit runs on its own and can raise an interrupt toward the host.
// R8: A port can act as a printer-style strobed output with busy and acknowledge handshake.
// R9: Every line is pulled up, so an undriven input reads as one.
// R10: Within a block the low address picks a port data register or the control register, eight bits per access.
package pio_pkg;

   // ==========================================================
   // sizes
   localparam int UNITS      = 2;
   localparam int PORT_W     = 8;
   localparam int PORTS      = 3;
   localparam int LINES      = UNITS * PORTS * PORT_W;
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 32;
   localparam int IRQ_W      = 4;

   // ==========================================================
   // address map (byte addresses)
   localparam int BLK_BIT    = 5;
   localparam int IDX_HI     = 4;
   localparam int IDX_LO     = 2;
   localparam logic [2:0] IDX_PORT_A = 3'h0;
   localparam logic [2:0] IDX_PORT_B = 3'h1;
   localparam logic [2:0] IDX_PORT_C = 3'h2;
   localparam logic [2:0] IDX_CTL    = 3'h3;
   localparam logic [ADDR_W-1:0] UNIT_SPAN     = 8'h40;
   localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 8'h40;
   localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 8'h44;

   // ==========================================================
   // control byte layout
   localparam int CTL_MODESET = 7;
   localparam int CTL_AMODE_HI = 6;
   localparam int CTL_AMODE_LO = 5;
   localparam int CTL_A_IN    = 4;
   localparam int CTL_CU_IN   = 3;
   localparam int CTL_B_MODE  = 2;
   localparam int CTL_B_IN    = 1;
   localparam int CTL_CL_IN   = 0;
   localparam int BSR_SEL_HI  = 3;
   localparam int BSR_SEL_LO  = 1;
   localparam int BSR_VAL     = 0;
   localparam logic [7:0] CTL_RST = 8'h9B;

   // ==========================================================
   // group a modes
   localparam logic [1:0] MODE_BASIC   = 2'h0;
   localparam logic [1:0] MODE_STROBED = 2'h1;
   localparam int         MODE_BIDIR_BIT = 1;

   // ==========================================================
   // third port line roles under handshake
   localparam int C_B_INTR = 0;
   localparam int C_B_FLAG = 1;
   localparam int C_B_HS   = 2;
   localparam int C_A_INTR = 3;
   localparam int C_A_STB  = 4;
   localparam int C_A_IBF  = 5;
   localparam int C_A_ACK  = 6;
   localparam int C_A_OBF  = 7;

endpackage

// ### pio_port8.sv
// one strobed 8-bit port with input latch, output register and handshake flags
`timescale 1ns/1ns
module pio_port8
   import pio_pkg::*;
(
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // mode
   input  wire logic              strb_en,
   input  wire logic              dir_in,
   input  wire logic              bidir,
   input  wire logic              clr,
   // handshake lines
   input  wire logic              stb_n,
   input  wire logic              ack_n,
   input  wire logic [PORT_W-1:0] lines,
   input  wire logic              inte_in,
   input  wire logic              inte_out,
   // host side
   input  wire logic              wr_pls,
   input  wire logic              rd_pls,
   input  wire logic [PORT_W-1:0] wdata,
   // results
   output logic      [PORT_W-1:0] in_lat_r,
   output logic      [PORT_W-1:0] out_r,
   output logic                   ibf_r,
   output logic                   obf_n_r,
   output logic                   intr,
   output logic                   ev
);

   logic stb_q_r;
   logic ack_q_r;
   logic intr_i_r;
   logic intr_o_r;

   // ==========================================================
   // edge detection
   wire in_act   = strb_en & (dir_in | bidir);
   wire out_act  = strb_en & (~dir_in | bidir);
   wire stb_fall = in_act & stb_q_r & ~stb_n;
   wire stb_rise = in_act & ~stb_q_r & stb_n;
   wire ack_fall = out_act & ack_q_r & ~ack_n;
   wire ack_rise = out_act & ~ack_q_r & ack_n;
   wire set_i    = stb_rise & ibf_r & inte_in;
   wire set_o    = ack_rise & obf_n_r & inte_out;

   // flags: set wins over clear
   wire ibf_nxt    = stb_fall | (ibf_r & ~rd_pls);                          // R4
   wire intr_i_nxt = set_i | (intr_i_r & ~rd_pls);                          // R4
   wire obf_n_nxt  = ~((wr_pls & out_act) | (~obf_n_r & ~ack_fall));        // R8
   wire intr_o_nxt = set_o | (intr_o_r & ~wr_pls);                          // R8

   assign intr = intr_i_r | intr_o_r;
   assign ev   = set_i | set_o;                                             // R7

   // ==========================================================
   // state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stb_q_r  <= 1'b1;
         ack_q_r  <= 1'b1;
         in_lat_r <= '0;
         out_r    <= '0;
         ibf_r    <= 1'b0;
         obf_n_r  <= 1'b1;
         intr_i_r <= 1'b0;
         intr_o_r <= 1'b0;
      end
      else
      begin
         stb_q_r  <= stb_n;
         ack_q_r  <= ack_n;
         in_lat_r <= stb_fall ? lines : in_lat_r;                           // R4
         out_r    <= clr ? '0 : (wr_pls ? wdata : out_r);
         ibf_r    <= ~clr & ibf_nxt;
         obf_n_r  <= clr | obf_n_nxt;
         intr_i_r <= ~clr & intr_i_nxt;
         intr_o_r <= ~clr & intr_o_nxt;
      end
   end

endmodule

// ### pio_irq.sv
// sticky interrupt status, mask and one level interrupt output
`timescale 1ns/1ns
module pio_irq
   import pio_pkg::*;
(
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // events
   input  wire logic [IRQ_W-1:0] ev,
   // register access
   input  wire logic             stat_wr,
   input  wire logic             mask_wr,
   input  wire logic [IRQ_W-1:0] wdata,
   // state
   output logic      [IRQ_W-1:0] stat_r,
   output logic      [IRQ_W-1:0] mask_r,
   output logic                  irq_r
);

   // write one to clear, a new event wins
   wire [IRQ_W-1:0] clr_bits = stat_wr ? wdata : '0;
   wire [IRQ_W-1:0] stat_nxt = ev | (stat_r & ~clr_bits);                  // R7
   wire [IRQ_W-1:0] mask_nxt = mask_wr ? wdata : mask_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stat_r <= '0;
         mask_r <= '0;
         irq_r  <= 1'b0;
      end
      else
      begin
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         irq_r  <= |(stat_nxt & mask_nxt);                                  // R7
      end
   end

endmodule

// ### pio_top.sv
// dual parallel i/o block: apb slave, two interface units, interrupt gating
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ns
module pio_top
   import pio_pkg::*;
(
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   output logic                   pready,
   output logic      [DATA_W-1:0] prdata,
   output logic                   pslverr,
   // parallel lines
   input  wire logic [LINES-1:0]  pio_in,
   input  wire logic [LINES-1:0]  pio_ext_oe,
   output logic      [LINES-1:0]  pio_out,
   output logic      [LINES-1:0]  pio_oe,
   // interrupt
   output logic                   irq
);

   // ==========================================================
   // helpers
   function automatic logic [1:0] cbit(input logic hs, input logic drv, input logic val,
                                       input logic lat, input logic boe);
      cbit = hs ? {drv, val} : {boe, lat};
   endfunction

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
      hit = (a == r);
   endfunction

   // ==========================================================
   // apb access
   logic                 pready_r;
   logic [DATA_W-1:0]    prdata_r;
   logic [LINES-1:0]     pio_out_r;
   logic [LINES-1:0]     pio_oe_r;
   logic [PORT_W-1:0]    rd_byte [UNITS*4];
   logic [LINES-1:0]     pin_o_nxt;
   logic [LINES-1:0]     pin_oe_nxt;
   logic [IRQ_W-1:0]     ev;
   logic [IRQ_W-1:0]     irq_stat;
   logic [IRQ_W-1:0]     irq_mask;
   logic                 irq_r;

   wire                  acc       = psel & penable & pready_r;
   wire                  acc_wr    = acc & pwrite;
   wire                  acc_rd    = acc & ~pwrite;
   wire                  in_units  = paddr < UNIT_SPAN;
   wire                  low_block_select  = in_units & ~paddr[BLK_BIT];     // R1
   wire                  high_block_select = in_units & paddr[BLK_BIT];      // R1
   wire [2:0]            idx       = paddr[IDX_HI:IDX_LO];                   // R10
   wire [1:0]            blk_sel   = {high_block_select, low_block_select};
   wire                  stat_hit  = hit(paddr, IRQ_STAT_ADDR);
   wire                  mask_hit  = hit(paddr, IRQ_MASK_ADDR);
   wire                  idx_ok    = idx <= IDX_CTL;
   wire [PORT_W-1:0]     wbyte     = pwdata[PORT_W-1:0];                     // R10
   wire [2:0]            rd_idx    = idx_ok ? idx : 3'h0;
   wire [PORT_W-1:0]     unit_rd   = rd_byte[{paddr[BLK_BIT], rd_idx[1:0]}];
   wire [DATA_W-1:0]     rd_val    = (in_units & idx_ok) ? {24'h000000, unit_rd} :
                                     stat_hit ? {28'h0000000, irq_stat} :
                                     mask_hit ? {28'h0000000, irq_mask} : '0;

   // ==========================================================
   // interface units
   genvar u;
   generate
      for (u = 0; u < UNITS; u = u + 1)
      begin : g_unit
         logic [1:0]        a_mode_r;
         logic              a_in_r;
         logic              cu_in_r;
         logic              b_mode_r;
         logic              b_in_r;
         logic              cl_in_r;
         logic [PORT_W-1:0] c_lat_r;
         logic [PORT_W-1:0] a_inlat;
         logic [PORT_W-1:0] a_out;
         logic [PORT_W-1:0] b_inlat;
         logic [PORT_W-1:0] b_out;
         logic              a_ibf;
         logic              a_obf_n;
         logic              a_intr;
         logic              a_ev;
         logic              b_ibf;
         logic              b_obf_n;
         logic              b_intr;
         logic              b_ev;
         logic [1:0]        cb [PORT_W];

         localparam int BASE = u * PORTS * PORT_W;

         // own selects
         wire sel    = blk_sel[u];
         wire wr_a   = acc_wr & sel & (idx == IDX_PORT_A);
         wire wr_b   = acc_wr & sel & (idx == IDX_PORT_B);
         wire wr_c   = acc_wr & sel & (idx == IDX_PORT_C);
         wire wr_ctl = acc_wr & sel & (idx == IDX_CTL);
         wire rd_a   = acc_rd & sel & (idx == IDX_PORT_A);
         wire rd_b   = acc_rd & sel & (idx == IDX_PORT_B);
         wire modeset = wr_ctl & wbyte[CTL_MODESET];
         wire bitop   = wr_ctl & ~wbyte[CTL_MODESET];
         wire [2:0] bsel = wbyte[BSR_SEL_HI:BSR_SEL_LO];

         // line levels with pull-up on undriven lines
         wire [PORT_W*PORTS-1:0] drv  = pio_oe_r[BASE +: PORT_W*PORTS];
         wire [PORT_W*PORTS-1:0] dval = pio_out_r[BASE +: PORT_W*PORTS];
         wire [PORT_W*PORTS-1:0] xoe  = pio_ext_oe[BASE +: PORT_W*PORTS];
         wire [PORT_W*PORTS-1:0] xin  = pio_in[BASE +: PORT_W*PORTS];
         wire [PORT_W*PORTS-1:0] lv   = drv & dval | ~drv & (~xoe | xin);  // R9
         wire [PORT_W-1:0] a_lv = lv[0 +: PORT_W];
         wire [PORT_W-1:0] b_lv = lv[PORT_W +: PORT_W];
         wire [PORT_W-1:0] c_lv = lv[2*PORT_W +: PORT_W];

         // mode decode
         wire a_bidir  = a_mode_r[MODE_BIDIR_BIT];                          // R5
         wire a_hs     = a_mode_r != MODE_BASIC;                            // R4
         wire a_hs_in  = a_hs & (a_in_r | a_bidir);
         wire a_hs_out = a_hs & (~a_in_r | a_bidir);
         wire b_hs     = b_mode_r;

         // control register and bit set/reset
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               a_mode_r <= CTL_RST[CTL_AMODE_HI:CTL_AMODE_LO];
               a_in_r   <= CTL_RST[CTL_A_IN];
               cu_in_r  <= CTL_RST[CTL_CU_IN];
               b_mode_r <= CTL_RST[CTL_B_MODE];
               b_in_r   <= CTL_RST[CTL_B_IN];
               cl_in_r  <= CTL_RST[CTL_CL_IN];
               c_lat_r  <= '0;
            end
            else if (modeset)
            begin
               a_mode_r <= wbyte[CTL_AMODE_HI:CTL_AMODE_LO];                // R2
               a_in_r   <= wbyte[CTL_A_IN];                                 // R3
               cu_in_r  <= wbyte[CTL_CU_IN];                                // R3
               b_mode_r <= wbyte[CTL_B_MODE];                               // R2
               b_in_r   <= wbyte[CTL_B_IN];                                 // R3
               cl_in_r  <= wbyte[CTL_CL_IN];                                // R3
               c_lat_r  <= '0;
            end
            else if (bitop)
            begin
               c_lat_r[bsel] <= wbyte[BSR_VAL];                             // R6
            end
            else if (wr_c)
            begin
               c_lat_r <= wbyte;
            end
         end

         // first port: strobed, output or two-way
         pio_port8 u_pa (
            .pclk     (pclk),
            .presetn  (presetn),
            .strb_en  (a_hs),
            .dir_in   (a_in_r),
            .bidir    (a_bidir),
            .clr      (modeset),
            .stb_n    (c_lv[C_A_STB]),
            .ack_n    (c_lv[C_A_ACK]),
            .lines    (a_lv),
            .inte_in  (c_lat_r[C_A_STB]),
            .inte_out (c_lat_r[C_A_ACK]),
            .wr_pls   (wr_a),
            .rd_pls   (rd_a),
            .wdata    (wbyte),
            .in_lat_r (a_inlat),
            .out_r    (a_out),
            .ibf_r    (a_ibf),
            .obf_n_r  (a_obf_n),
            .intr     (a_intr),
            .ev       (a_ev)
         );

         // second port: strobed one way only
         pio_port8 u_pb (
            .pclk     (pclk),
            .presetn  (presetn),
            .strb_en  (b_hs),
            .dir_in   (b_in_r),
            .bidir    (1'b0),
            .clr      (modeset),
            .stb_n    (c_lv[C_B_HS]),
            .ack_n    (c_lv[C_B_HS]),
            .lines    (b_lv),
            .inte_in  (c_lat_r[C_B_HS]),
            .inte_out (c_lat_r[C_B_HS]),
            .wr_pls   (wr_b),
            .rd_pls   (rd_b),
            .wdata    (wbyte),
            .in_lat_r (b_inlat),
            .out_r    (b_out),
            .ibf_r    (b_ibf),
            .obf_n_r  (b_obf_n),
            .intr     (b_intr),
            .ev       (b_ev)
         );

         // third port line roles
         assign cb[C_B_INTR] = cbit(b_hs, 1'b1, b_intr, c_lat_r[C_B_INTR], ~cl_in_r);    // R4
         assign cb[C_B_FLAG] = cbit(b_hs, 1'b1, b_in_r ? b_ibf : b_obf_n,
                                    c_lat_r[C_B_FLAG], ~cl_in_r);                        // R4
         assign cb[C_B_HS]   = cbit(b_hs, 1'b0, 1'b0, c_lat_r[C_B_HS], ~cl_in_r);        // R4
         assign cb[C_A_INTR] = cbit(a_hs, 1'b1, a_intr, c_lat_r[C_A_INTR], ~cl_in_r);    // R5
         assign cb[C_A_STB]  = cbit(a_hs_in, 1'b0, 1'b0, c_lat_r[C_A_STB], ~cu_in_r);
         assign cb[C_A_IBF]  = cbit(a_hs_in, 1'b1, a_ibf, c_lat_r[C_A_IBF], ~cu_in_r);
         assign cb[C_A_ACK]  = cbit(a_hs_out, 1'b0, 1'b0, c_lat_r[C_A_ACK], ~cu_in_r);   // R8
         assign cb[C_A_OBF]  = cbit(a_hs_out, 1'b1, a_obf_n, c_lat_r[C_A_OBF], ~cu_in_r); // R8

         genvar k;
         for (k = 0; k < PORT_W; k = k + 1)
         begin : g_cbit
            assign pin_o_nxt[BASE + 2*PORT_W + k]  = cb[k][0];
            assign pin_oe_nxt[BASE + 2*PORT_W + k] = cb[k][1];
         end

         // first and second port drive
         assign pin_o_nxt[BASE +: PORT_W]           = a_out;
         assign pin_oe_nxt[BASE +: PORT_W]          = a_bidir ? {PORT_W{~c_lv[C_A_ACK]}} : // R5
                                                      {PORT_W{~a_in_r}};                    // R3
         assign pin_o_nxt[BASE + PORT_W +: PORT_W]  = b_out;
         assign pin_oe_nxt[BASE + PORT_W +: PORT_W] = {PORT_W{~b_in_r}};                   // R3

         // read values
         assign rd_byte[u*4 + 0] = a_hs_in ? a_inlat : (a_in_r ? a_lv : a_out);
         assign rd_byte[u*4 + 1] = (b_hs & b_in_r) ? b_inlat : (b_in_r ? b_lv : b_out);
         assign rd_byte[u*4 + 2] = c_lv;
         assign rd_byte[u*4 + 3] = {1'b1, a_mode_r, a_in_r, cu_in_r, b_mode_r, b_in_r, cl_in_r};
         assign ev[u*2 +: 2]     = {b_ev, a_ev};                            // R7
      end
   endgenerate

   // ==========================================================
   // interrupts
   pio_irq u_irq (
      .pclk    (pclk),
      .presetn (presetn),
      .ev      (ev),
      .stat_wr (acc_wr & stat_hit),
      .mask_wr (acc_wr & mask_hit),
      .wdata   (pwdata[IRQ_W-1:0]),
      .stat_r  (irq_stat),
      .mask_r  (irq_mask),
      .irq_r   (irq_r)
   );

   // ==========================================================
   // registered outputs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r  <= 1'b0;
         prdata_r  <= '0;
         pio_out_r <= '0;
         pio_oe_r  <= '0;
      end
      else
      begin
         pready_r  <= psel & penable & ~pready_r;
         prdata_r  <= (psel & penable & ~pready_r & ~pwrite) ? rd_val : '0;
         pio_out_r <= pin_o_nxt;
         pio_oe_r  <= pin_oe_nxt;
      end
   end

   assign pready  = pready_r;
   assign prdata  = prdata_r;
   assign pslverr = 1'b0;
   assign pio_out = pio_out_r;
   assign pio_oe  = pio_oe_r;
   assign irq     = irq_r;

endmodule

// ### pio_assertions.sv
// concurrent checks on the ports of the dual parallel i/o block
`timescale 1ns/1ns
module pio_chk
   import pio_pkg::*;
(
   // clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   // apb
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic              pready,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic              pslverr,
   // lines and interrupt
   input wire logic [LINES-1:0]  pio_out,
   input wire logic [LINES-1:0]  pio_oe,
   input wire logic              irq
);
   // ==========================================================
   // helpers
   wire wr = psel && penable && pready && pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ==========================================================
   // assertions
   ready_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("pready missing in second access cycle");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero outside answer");
   rdata_byte_a: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("prdata wider than one byte");
   no_error_a: assert property (pslverr == 1'b0)
      else $error("pslverr raised");
   reset_idle_a: assert property ($rose(presetn) |-> pio_oe == '0 && !irq)
      else $error("lines or irq active after reset");
   out_follow_a: assert property (wr && paddr == 8'h00 |-> ##2
      (pio_oe[7:0] != 8'hFF || pio_out[7:0] == $past(pwdata[7:0], 2)))
      else $error("first port output does not follow write");
   bit_set_a: assert property (wr && paddr == 8'h0C && !pwdata[7] |-> ##2
      (!pio_oe[16 + $past(pwdata[3:1], 2)] || pio_out[16 + $past(pwdata[3:1], 2)] == $past(pwdata[0], 2)))
      else $error("single line set or clear not applied");
   mask_off_a: assert property (wr && paddr == 8'h44 && pwdata[3:0] == 4'h0 |-> ##2 !irq[*3])
      else $error("irq high with all events masked");

   // ==========================================================
   // covers
   write_c: cover property (wr);
   irq_c: cover property ($rose(irq));
   bsr_c: cover property (wr && paddr == 8'h0C && !pwdata[7]);
endmodule

bind pio_top pio_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .pio_out(pio_out), .pio_oe(pio_oe), .irq(irq));

// ### pio_ext.sv
// external equipment on the parallel lines: pull-ups, bench drive, printer ack
`timescale 1ns/1ns
module pio_ext
   import pio_pkg::*;
(
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // bench commands
   input  wire logic             auto_ack,
   input  wire logic [LINES-1:0] drv_val,
   input  wire logic [LINES-1:0] drv_en,
   // block side
   input  wire logic [LINES-1:0] pio_out,
   input  wire logic [LINES-1:0] pio_oe,
   output logic      [LINES-1:0] pio_in,
   output logic      [LINES-1:0] pio_ext_oe,
   output logic      [LINES-1:0] lvl
);
   logic [2:0]       ack_cnt_r;
   logic [LINES-1:0] val;
   logic [LINES-1:0] en;

   // ==========================================================
   // printer ack: low for two cycles, from one cycle after output-full goes low
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         ack_cnt_r <= 3'h0;
      else if (ack_cnt_r != 3'h0)
         ack_cnt_r <= ack_cnt_r - 3'h1;
      else if (auto_ack && pio_oe[23] && !pio_out[23])
         ack_cnt_r <= 3'h4;

   // ==========================================================
   // line levels, never driving against the block
   assign val = auto_ack ? {drv_val[47:23], ack_cnt_r < 3'h3, drv_val[21:0]} : drv_val;
   assign en = (drv_en | (LINES'(auto_ack) << 22)) & ~pio_oe;
   assign pio_ext_oe = en;
   assign pio_in = (val & en) | ~en;
   assign lvl = (pio_out & pio_oe) | (pio_in & ~pio_oe);
endmodule

// ### tb_dual_parallel_io_module.sv
// self-checking bench for the dual parallel i/o block
`timescale 1ns/1ns
module tb_dual_parallel_io_module
   import pio_pkg::*;
;
   logic              pclk = 1'b0;
   logic              presetn = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic              auto_ack = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [DATA_W-1:0] prdata;
   logic [DATA_W-1:0] rv;
   logic              pready;
   logic              pslverr;
   logic              irq;
   logic [LINES-1:0]  pio_in;
   logic [LINES-1:0]  pio_ext_oe;
   logic [LINES-1:0]  pio_out;
   logic [LINES-1:0]  pio_oe;
   logic [LINES-1:0]  lvl;
   logic [LINES-1:0]  drv_val = '0;
   logic [LINES-1:0]  drv_en = '0;
   int                fail_count = 0;
   int                samples_checked = 0;
   int                cyc = 0;

   pio_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .pio_in(pio_in), .pio_ext_oe(pio_ext_oe), .pio_out(pio_out),
      .pio_oe(pio_oe), .irq(irq));
   pio_ext ext (.pclk(pclk), .presetn(presetn), .auto_ack(auto_ack), .drv_val(drv_val),
      .drv_en(drv_en), .pio_out(pio_out), .pio_oe(pio_oe), .pio_in(pio_in),
      .pio_ext_oe(pio_ext_oe), .lvl(lvl));

   // ==========================================================
   // clock and timeout
   always #10 pclk = ~pclk;
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fail_count++;
         end_of_test();
      end
   end

   // ==========================================================
   // tasks
   task end_of_test;
      if (fail_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         $display("Error %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk("read", {24'h0, e}, rv);
   endtask
   task strobe(input logic [7:0] d);
      drv_en[7:0] <= 8'hFF;
      drv_val[7:0] <= d;
      drv_en[20] <= 1'b1;
      drv_val[20] <= 1'b0;
      repeat (3) @(posedge pclk);
      drv_en[20] <= 1'b0;
      repeat (4) @(posedge pclk);
      drv_en[7:0] <= 8'h00;
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h0C, 8'h9B);
      rd(8'h2C, 8'h9B);
      rd(8'h00, 8'hFF);
      rd(8'h1C, 8'h00);
      rd(8'h48, 8'h00);
      wr(8'h44, 8'h00);
      wr(8'h0C, 8'h8A);
      wr(8'h00, 8'h5A);
      drv_en[23:20] <= 4'hF;
      drv_val[23:20] <= 4'hA;
      repeat (2) @(posedge pclk);
      chk("lines", 32'h5A, {24'h0, lvl[7:0]});
      chk("oe", 32'h0F00FF, {8'h0, pio_oe[23:0]});
      rd(8'h08, 8'hA0);
      wr(8'h0C, 8'h05);
      rd(8'h08, 8'hA4);
      wr(8'h0C, 8'h04);
      rd(8'h08, 8'hA0);
      rd(8'h20, 8'hFF);
      drv_en <= '0;
      wr(8'h0C, 8'hBB);
      wr(8'h0C, 8'h09);
      wr(8'h44, 8'h01);
      strobe(8'h3C);
      chk("irq", 32'h1, {31'h0, irq});
      rd(8'h40, 8'h01);
      rd(8'h00, 8'h3C);
      rd(8'h08, 8'hD7);
      wr(8'h40, 8'h01);
      rd(8'h40, 8'h00);
      chk("irq", 32'h0, {31'h0, irq});
      wr(8'h44, 8'h00);
      strobe(8'h11);
      rd(8'h40, 8'h01);
      chk("irq", 32'h0, {31'h0, irq});
      rd(8'h00, 8'h11);
      wr(8'h40, 8'h01);
      wr(8'h0C, 8'hAB);
      wr(8'h0C, 8'h0D);
      auto_ack <= 1'b1;
      wr(8'h44, 8'h01);
      wr(8'h00, 8'h77);
      repeat (10) @(posedge pclk);
      chk("lines", 32'h77, {24'h0, lvl[7:0]});
      rd(8'h40, 8'h01);
      chk("irq", 32'h1, {31'h0, irq});
      wr(8'h40, 8'h01);
      wr(8'h0C, 8'hDB);
      repeat (2) @(posedge pclk);
      chk("oe", 32'h0, {24'h0, pio_oe[7:0]});
      wr(8'h00, 8'h99);
      rv = '0;
      repeat (10)
      begin
         @(posedge pclk);
         if (pio_oe[7:0] === 8'hFF)
            rv[7:0] = lvl[7:0];
      end
      chk("bus", 32'h99, rv);
      chk("oe", 32'h0, {24'h0, pio_oe[7:0]});
      wr(8'h2C, 8'h84);
      wr(8'h2C, 8'h05);
      wr(8'h24, 8'h5A);
      rd(8'h28, 8'h04);
      drv_en[42] <= 1'b1;
      repeat (3) @(posedge pclk);
      drv_en[42] <= 1'b0;
      repeat (3) @(posedge pclk);
      rd(8'h28, 8'h07);
      rd(8'h40, 8'h08);
      end_of_test();
   end
endmodule
